// *** psp_pkg.sv ***
// constants, types and decode helpers for the pin driver serial configuration port
package psp_pkg;

    // ------------------------------------------------------------
    // clocking
    // ------------------------------------------------------------
    localparam int unsigned CLK_HZ = 40_000_000;
    localparam int unsigned SCLK_MAX_HZ = 50_000_000;
    localparam int unsigned SYNC_STAGES = 3;

    // ------------------------------------------------------------
    // frame layout
    // ------------------------------------------------------------
    localparam int unsigned FRAME_W = 24;
    localparam int unsigned DATA_W = 16;
    localparam int unsigned NUM_REGS = 16;
    localparam int unsigned NUM_CH = 2;
    localparam int unsigned BIT_SPARE = 23;
    localparam int unsigned BIT_CAL = 22;
    localparam int unsigned BIT_CH1 = 21;
    localparam int unsigned BIT_CH0 = 20;
    localparam int unsigned IDX_MSB = 19;
    localparam int unsigned IDX_LSB = 16;
    localparam int unsigned DATA_MSB = 15;
    localparam int unsigned DATA_LSB = 0;

    // ------------------------------------------------------------
    // register numbers and power-up values
    // ------------------------------------------------------------
    localparam logic [3:0] REG_DRV_CTRL = 4'h0;
    localparam logic [3:0] REG_PMU_CTRL = 4'h8;
    localparam logic [3:0] REG_OFFSET_LEVEL = 4'hd;
    localparam logic [15:0] RST_DRV_CTRL = 16'h0004;
    localparam logic [15:0] RST_DRV_CAL = 16'h0008;
    localparam logic [15:0] RST_PMU_CTRL = 16'h0003;
    localparam logic [15:0] RST_ZERO = 16'h0000;
    localparam logic [23:0] RST_FRAME = 24'h00_0000;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef logic [15:0] psp_word_t;
    typedef logic [15:0][15:0] psp_bank_t;

    // ------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------
    function automatic logic [1:0] psp_chan_sel(input logic [23:0] frame);
        return {frame[BIT_CH1], frame[BIT_CH0]};
    endfunction

    function automatic logic [3:0] psp_reg_idx(input logic [23:0] frame);
        return frame[IDX_MSB:IDX_LSB];
    endfunction

    function automatic psp_word_t psp_level_reset(input logic [3:0] idx);
        if (idx == REG_DRV_CTRL) begin
            return RST_DRV_CTRL;
        end else if (idx == REG_PMU_CTRL) begin
            return RST_PMU_CTRL;
        end
        return RST_ZERO;
    endfunction

    function automatic psp_word_t psp_cal_reset(input logic [3:0] idx);
        return (idx == REG_DRV_CTRL) ? RST_DRV_CAL : RST_ZERO;
    endfunction

endpackage

// *** psp_sync.sv ***
// three-stage input synchroniser with agreement filter and edge pulses
`timescale 1ns/1ps
`default_nettype none

module psp_sync #(
    parameter logic RST_VAL = 1'b0
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rstn_i,
    // asynchronous input
    input wire logic async_i,
    // filtered level and edges
    output logic level_o,
    output logic rise_o,
    output logic fall_o
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [2:0] ff;
        logic filt;
        logic rise;
        logic fall;
    } psp_sync_state_t;

    localparam psp_sync_state_t RESET_STATE = '{ff: {3{RST_VAL}}, filt: RST_VAL, rise: 1'b0, fall: 1'b0};

    psp_sync_state_t s;
    psp_sync_state_t next_s;

    // stage 0 feeds stage 1 only; the filter looks at stages 1 and 2
    always_comb begin
        next_s = s;
        next_s.ff = {s.ff[1:0], async_i};
        next_s.rise = 1'b0;
        next_s.fall = 1'b0;
        if (s.ff[1] == s.ff[2]) begin
            next_s.filt = s.ff[2];
            next_s.rise = s.ff[2] & ~s.filt;
            next_s.fall = ~s.ff[2] & s.filt;
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            s <= RESET_STATE;
        end else begin
            s <= next_s;
        end
    end

    assign level_o = s.filt;
    assign rise_o = s.rise;
    assign fall_o = s.fall;

endmodule // psp_sync

`default_nettype wire

// *** psp_shreg.sv ***
// 24-bit serial shift register with buffered last-bit output
`timescale 1ns/1ps
`default_nettype none

module psp_shreg (
    // clock and reset
    input wire logic clk_i,
    input wire logic rstn_i,
    // shift request and serial bit
    input wire logic shift_i,
    input wire logic bit_i,
    // parallel frame and serial echo
    output logic [23:0] frame_o,
    output logic dout_o
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [23:0] frame;
        logic dout;
    } psp_shreg_state_t;

    psp_shreg_state_t s;
    psp_shreg_state_t next_s;

    always_comb begin
        next_s = s;
        if (shift_i) begin
            next_s.frame = {s.frame[22:0], bit_i};
        end
        // the echo lags the register by one clock so it never glitches mid-shift
        next_s.dout = s.frame[psp_pkg::BIT_SPARE];
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            s <= '{frame: psp_pkg::RST_FRAME, dout: 1'b0};
        end else begin
            s <= next_s;
        end
    end

    assign frame_o = s.frame;
    assign dout_o = s.dout;

endmodule // psp_shreg

`default_nettype wire

// *** psp_port.sv ***
// serial configuration port: frame capture, input stage and control/level/calibration registers
//
// What this block does
// - serial clock is sampled by clk_i, so at 40MHz it must stay well below 20MHz; host stays under it.
// - while select low, each serial clock rise shifts data into 24-bit register.
// - strobe high at select rise: a non-calibration frame goes only to the input stage.
// - strobe falling edge copies held input stage into control and level registers.
// - strobe low at select rise: stage transparent, registers update at select rise.
// - calibration writes apply at select rise regardless of strobe level.
// - serial output is buffered last shift bit, previous frame shifts out fully.
// - frame with both channel enables zero changes no register.
// - address bit A6 routes write to the calibration register of selected DAC.
// - A5 enables channel 1, A4 enables channel 0; all enabled channels update.
// - most significant address bit is ignored.
// - four lowest address bits pick one of sixteen registers.
// - sixteen bits after address are payload, D15 most significant.
// - power-up: driver control 0x0004, driver calibration 0x0008, PMU control 0x0003.
// - register 13: channel 0 is voltage offset, channel 1 current offset.
`timescale 1ns/1ps
`default_nettype none

module psp_port (
    // clock and reset
    input wire logic clk_i,
    input wire logic rstn_i,
    // serial link pins
    input wire logic sclk_i,
    input wire logic cs_n_i,
    input wire logic din_i,
    input wire logic load_n_i,
    output logic dout_o,
    // register contents, per channel, per register number
    output logic [1:0][15:0][15:0] level_o,
    output logic [1:0][15:0][15:0] cal_o,
    output logic [1:0][15:0] pending_o,
    // shared offset levels
    output logic [15:0] voltage_offset_level_o,
    output logic [15:0] current_offset_level_o
);

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    // the link clock is sampled, not used as a clock, so a 40MHz system clock
    // only follows serial clocks well below 20MHz; full rate needs a faster clk_i
    logic sclk_rise;
    logic cs_n_level;
    logic cs_rise;
    logic din_level;
    logic load_n_level;
    logic load_fall;
    logic [23:0] frame;

    psp_sync #(.RST_VAL(1'b0)) u_sync_sclk (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .async_i(sclk_i),
        .level_o(),
        .rise_o(sclk_rise),
        .fall_o()
    );

    psp_sync #(.RST_VAL(1'b1)) u_sync_cs (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .async_i(cs_n_i),
        .level_o(cs_n_level),
        .rise_o(cs_rise),
        .fall_o()
    );

    psp_sync #(.RST_VAL(1'b0)) u_sync_din (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .async_i(din_i),
        .level_o(din_level),
        .rise_o(),
        .fall_o()
    );

    psp_sync #(.RST_VAL(1'b1)) u_sync_load (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .async_i(load_n_i),
        .level_o(load_n_level),
        .rise_o(),
        .fall_o(load_fall)
    );

    // ------------------------------------------------------------
    // shift register
    // ------------------------------------------------------------
    psp_shreg u_shreg (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .shift_i(sclk_rise & ~cs_n_level),
        .bit_i(din_level),
        .frame_o(frame),
        .dout_o(dout_o)
    );

    // ------------------------------------------------------------
    // register state
    // ------------------------------------------------------------
    typedef struct packed {
        psp_pkg::psp_bank_t [1:0] level;
        psp_pkg::psp_bank_t [1:0] cal;
        psp_pkg::psp_bank_t [1:0] hold;
        logic [1:0][15:0] pending;
    } psp_state_t;

    function automatic psp_state_t psp_make_reset();
        psp_state_t r;
        r = '0;
        for (int ch = 0; ch < psp_pkg::NUM_CH; ch++) begin
            for (int i = 0; i < psp_pkg::NUM_REGS; i++) begin
                r.level[ch][i] = psp_pkg::psp_level_reset(4'(i));
                r.hold[ch][i] = psp_pkg::psp_level_reset(4'(i));
                r.cal[ch][i] = psp_pkg::psp_cal_reset(4'(i));
            end
        end
        return r;
    endfunction

    localparam psp_state_t RESET_STATE = psp_make_reset();

    psp_state_t s;
    psp_state_t next_s;

    // ------------------------------------------------------------
    // update logic
    // ------------------------------------------------------------
    always_comb begin
        logic [1:0] sel;
        logic [3:0] idx;
        logic [15:0] data;
        sel = psp_pkg::psp_chan_sel(frame);
        idx = psp_pkg::psp_reg_idx(frame);
        data = frame[psp_pkg::DATA_MSB:psp_pkg::DATA_LSB];
        next_s = s;
        // strobe edge applies held words first; a frame closing in the same
        // cycle is then handled on top of it, so it is never lost
        if (load_fall) begin
            for (int ch = 0; ch < psp_pkg::NUM_CH; ch++) begin
                for (int i = 0; i < psp_pkg::NUM_REGS; i++) begin
                    if (s.pending[ch][i]) begin
                        next_s.level[ch][i] = s.hold[ch][i];
                        next_s.pending[ch][i] = 1'b0;
                    end
                end
            end
        end
        if (cs_rise) begin
            for (int ch = 0; ch < psp_pkg::NUM_CH; ch++) begin
                if (sel[ch]) begin
                    if (frame[psp_pkg::BIT_CAL]) begin
                        // the PMU control slot has no calibration register
                        if (idx != psp_pkg::REG_PMU_CTRL) begin
                            next_s.cal[ch][idx] = data;
                        end
                    end else begin
                        next_s.hold[ch][idx] = data;
                        if (!load_n_level) begin
                            next_s.level[ch][idx] = data;
                            next_s.pending[ch][idx] = 1'b0;
                        end else begin
                            next_s.pending[ch][idx] = 1'b1;
                        end
                    end
                end
            end
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            s <= RESET_STATE;
        end else begin
            s <= next_s;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign level_o = s.level;
    assign cal_o = s.cal;
    assign pending_o = s.pending;
    assign voltage_offset_level_o = s.level[0][psp_pkg::REG_OFFSET_LEVEL];
    assign current_offset_level_o = s.level[1][psp_pkg::REG_OFFSET_LEVEL];

endmodule // psp_port

`default_nettype wire

// *** psp_port_sva.sv ***
// assertion checker for the serial configuration port
`timescale 1ns/1ps
`default_nettype none
module psp_port_sva (
    // clock and reset
    input wire logic clk_i,
    input wire logic rstn_i,
    // serial pins
    input wire logic sclk_i,
    input wire logic cs_n_i,
    input wire logic din_i,
    input wire logic load_n_i,
    input wire logic dout_o,
    // register contents
    input wire logic [1:0][15:0][15:0] level_o,
    input wire logic [1:0][15:0][15:0] cal_o,
    input wire logic [1:0][15:0] pending_o,
    input wire logic [15:0] voltage_offset_level_o,
    input wire logic [15:0] current_offset_level_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    // cycles since select rise and strobe fall; saturate so old events never look fresh
    logic [3:0] cs_cnt;
    logic [3:0] ld_cnt;
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cs_cnt <= 4'hf;
            ld_cnt <= 4'hf;
        end else begin
            cs_cnt <= $rose(cs_n_i) ? 4'h0 : ((cs_cnt == 4'hf) ? cs_cnt : cs_cnt + 4'h1);
            ld_cnt <= $fell(load_n_i) ? 4'h0 : ((ld_cnt == 4'hf) ? ld_cnt : ld_cnt + 4'h1);
        end
    end
    a_reset_values: assert property ($rose(rstn_i) |-> level_o[0][0] == 16'h0004 && level_o[1][8] == 16'h0003
        && cal_o[0][0] == 16'h0008 && pending_o == '0) else $error("power-up values wrong");
    a_offset_pair: assert property (voltage_offset_level_o == level_o[0][13]
        && current_offset_level_o == level_o[1][13]) else $error("offset outputs differ");
    a_cal_eight_empty: assert property (cal_o[0][8] == '0 && cal_o[1][8] == '0) else $error("cal 8 set");
    a_idle_dout: assert property (cs_n_i [*8] |-> $stable(dout_o)) else $error("shift while deselected");
    a_level_cause: assert property (!$stable(level_o) |-> cs_cnt <= 4'ha || ld_cnt <= 4'ha)
        else $error("level change without cause");
    a_cal_cause: assert property (!$stable(cal_o) |-> cs_cnt <= 4'ha) else $error("cal change off select");
    a_hold_stage: assert property ($rose(|pending_o) |-> $stable(level_o)) else $error("held write applied");
    a_load_drain: assert property (cs_n_i [*8] ##0 $fell(load_n_i) |-> ##[1:8] pending_o == '0)
        else $error("held words not applied");
    cover property ($rose(|pending_o));
    cover property (!$stable(cal_o));
    cover property ($fell(load_n_i) ##[1:8] !$stable(level_o));
endmodule // psp_port_sva
bind psp_port psp_port_sva chk (.clk_i(clk_i), .rstn_i(rstn_i), .sclk_i(sclk_i), .cs_n_i(cs_n_i), .din_i(din_i),
    .load_n_i(load_n_i), .dout_o(dout_o), .level_o(level_o), .cal_o(cal_o), .pending_o(pending_o),
    .voltage_offset_level_o(voltage_offset_level_o), .current_offset_level_o(current_offset_level_o));
`default_nettype wire

// *** psp_host.sv ***
// host controller model driving the serial pins and update strobe
`timescale 1ns/1ps
`default_nettype none
module psp_host (
    // clock
    input wire logic clk_i,
    // pins toward the port
    output logic sclk_o,
    output logic cs_n_o,
    output logic din_o,
    output logic load_n_o,
    input wire logic dout_i
);
    initial begin
        sclk_o = 1'b0;
        cs_n_o = 1'b1;
        din_o = 1'b0;
        load_n_o = 1'b1;
    end
    task automatic step(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    // 8 clocks a serial period: 5MHz, well under the ceiling and slow enough for the sampler
    task automatic xfer(input logic [23:0] f, output logic [23:0] rx);
        cs_n_o = 1'b0;
        step(4);
        for (int i = 23; i >= 0; i--) begin
            din_o = f[i];
            step(4);
            // the echo settles a few clocks after each shift, so read it just before the next rise
            rx[i] = dout_i;
            sclk_o = 1'b1;
            step(4);
            sclk_o = 1'b0;
        end
        step(4);
        cs_n_o = 1'b1;
        din_o = ~f[0];
        step(12);
    endtask
    task automatic idle_clocks(input int n);
        for (int i = 0; i < n; i++) begin
            sclk_o = 1'b1;
            din_o = ~din_o;
            step(4);
            sclk_o = 1'b0;
            step(4);
        end
    endtask
    task automatic strobe(input logic v);
        load_n_o = v;
        step(12);
    endtask
endmodule // psp_host
`default_nettype wire

// *** psp_port_tb_top.sv ***
// self-checking testbench for the serial configuration port
`timescale 1ns/1ps
`default_nettype none
module psp_port_tb_top;
    logic clk_i;
    logic rstn_i;
    logic sclk, cs_n, din, load_n, dout;
    logic [1:0][15:0][15:0] level;
    logic [1:0][15:0][15:0] cal;
    logic [1:0][15:0] pend;
    logic [15:0] v_ofs;
    logic [15:0] i_ofs;
    logic [23:0] rx;
    int err_count = 0;
    int num_checks = 0;
    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end
    psp_host host (.clk_i(clk_i), .sclk_o(sclk), .cs_n_o(cs_n), .din_o(din), .load_n_o(load_n), .dout_i(dout));
    psp_port uut (.clk_i(clk_i), .rstn_i(rstn_i), .sclk_i(sclk), .cs_n_i(cs_n), .din_i(din), .load_n_i(load_n),
        .dout_o(dout), .level_o(level), .cal_o(cal), .pending_o(pend), .voltage_offset_level_o(v_ofs),
        .current_offset_level_o(i_ofs));
    task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %0t %s: got %h want %h", $time, what, got, exp);
        end
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic do_reset;
        rstn_i = 1'b0;
        repeat (2) @(posedge clk_i);
        #1;
        rstn_i = 1'b1;
        repeat (4) @(posedge clk_i);
        #1;
    endtask
    task automatic t_reset;
        check(level[0][0], 16'h0004, "drv ctrl");
        check(level[1][8], 16'h0003, "pmu ctrl");
        check(cal[1][0], 16'h0008, "drv cal");
        check(cal[0][0], 16'h0008, "drv cal ch0");
        check(level[0][13], 16'h0000, "offset");
        check(cal[1][2], 16'h0000, "cal");
        check({14'h0000, pend[1][13], pend[0][0]}, 16'h0000, "pending");
    endtask
    // strobe low: frame lands at select rise; spare address bit set, test mux bits zero
    task automatic t_direct;
        host.strobe(1'b0);
        host.xfer(24'h90_01f3, rx);
        check(level[0][0], 16'h01f3, "ch0 write");
        check(level[1][0], 16'h0004, "ch1 kept");
        // calibration write with the strobe low lands in the calibration bank only
        host.xfer(24'h50_00aa, rx);
        check(cal[0][0], 16'h00aa, "cal strobe low");
        check(level[0][0], 16'h01f3, "level after cal");
        host.strobe(1'b1);
    endtask
    // distinct words per channel so a swapped offset mapping shows up
    task automatic t_held;
        host.xfer(24'h3d_1234, rx);
        host.xfer(24'h2d_5678, rx);
        check(level[0][13], 16'h0000, "held ch0");
        check(level[1][13], 16'h0000, "held ch1");
        check({15'h0000, pend[1][13]}, 16'h0001, "pending");
        host.strobe(1'b0);
        check(v_ofs, 16'h1234, "voltage offset");
        check(i_ofs, 16'h5678, "current offset");
        check({15'h0000, pend[0][13]}, 16'h0000, "drained");
        host.strobe(1'b1);
    endtask
    task automatic t_cal;
        host.xfer(24'h62_0f0f, rx);
        check(cal[1][2], 16'h0f0f, "cal write");
        check(level[1][2], 16'h0000, "level kept");
        check({15'h0000, pend[1][2]}, 16'h0000, "cal not held");
        // the measurement-unit control slot has no calibration word
        host.xfer(24'h78_ffff, rx);
        check(cal[0][8] | cal[1][8], 16'h0000, "no cal 8");
        check(level[1][8], 16'h0003, "pmu ctrl kept");
    endtask
    // readback frames address no channel; idle clocks between them must not shift
    task automatic t_echo;
        host.xfer(24'h0f_abcd, rx);
        host.idle_clocks(5);
        host.xfer(24'h8a_5555, rx);
        check(rx[23:8], 16'h0fab, "echo high");
        check({8'h00, rx[7:0]}, 16'h00cd, "echo low");
        check(level[0][15], 16'h0000, "no-op 15");
        check(level[0][10], 16'h0000, "no-op 10");
    endtask
    initial begin
        do_reset();
        t_reset();
        t_direct();
        t_held();
        t_cal();
        t_echo();
        do_reset();
        t_reset();
        results();
    end
    initial begin
        #500us;
        err_count++;
        results();
    end
endmodule // psp_port_tb_top
`default_nettype wire
